/* verilog/ums_pkg.sv */
// constants for the modem status and baud generator block
package ums_pkg;
    // register byte offsets on the AHB-Lite bus
    localparam logic [7:0] OFS_DIV_LO     = 8'h00;
    localparam logic [7:0] OFS_DIV_HI_IER = 8'h04;
    localparam logic [7:0] OFS_LINE_CTRL  = 8'h0C;
    localparam logic [7:0] OFS_MODEM_CTRL = 8'h10;
    localparam logic [7:0] OFS_MODEM_STAT = 8'h18;
    localparam int unsigned ADDR_LSB      = 2;
    localparam int unsigned ADDR_MSB      = 7;

    // line control fields
    localparam int unsigned LCTL_DIV_ACCESS = 7;
    // interrupt enable fields
    localparam int unsigned IER_MSI = 3;
    // modem control fields
    localparam int unsigned MCTL_DTR       = 0;
    localparam int unsigned MCTL_RTS       = 1;
    localparam int unsigned MCTL_USER_A    = 2;
    localparam int unsigned MCTL_USER_B    = 3;
    localparam int unsigned MCTL_LOOP      = 4;
    localparam int unsigned MCTL_AUTO_FLOW = 5;
    localparam int unsigned MCTL_W         = 6;
    // modem line status: change flags low nibble, levels high nibble
    localparam int unsigned MSTAT_CTS_CHG   = 0;
    localparam int unsigned MSTAT_DSR_CHG   = 1;
    localparam int unsigned MSTAT_RING_EDGE = 2;
    localparam int unsigned MSTAT_DCD_CHG   = 3;
    localparam int unsigned MSTAT_LVL_LSB   = 4;
    // index of each modem line within the 4-bit line vectors
    localparam int unsigned LN_CTS = 0;
    localparam int unsigned LN_DSR = 1;
    localparam int unsigned LN_RI  = 2;
    localparam int unsigned LN_DCD = 3;

    localparam logic [7:0]  REG_RST  = 8'h00;
    localparam logic [15:0] DIV_RST  = 16'h0000;
    localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;
    localparam logic        HRESP_OKAY    = 1'h0;

    // timing figures
    localparam int unsigned DIV_W          = 16;
    localparam int unsigned BAUD_OVERSAMP  = 16;
    localparam int unsigned REF_CLK_MAX_HZ = 16_000_000;
    localparam int unsigned MCLK_HZ        = 25_000_000;
endpackage : ums_pkg

/* verilog/ums_baud_gen.sv */
// programmable divider producing the 16x baud enable
`timescale 1ns/1ps
module ums_baud_gen import ums_pkg::*; #(
    parameter int unsigned W = DIV_W
) (
    input  wire logic         mclk,
    input  wire logic         rst_n,
    input  wire logic [W-1:0] divisor,
    input  wire logic         load,
    input  wire logic [W-1:0] load_val,
    output logic              tick_16x
);
    generate
        if (W < 1 || W > DIV_W) begin : g_bad_w
            $error("ums_baud_gen: divisor width out of range");
        end
    endgenerate

    logic [W-1:0] cnt_q;
    logic         tick_q;

    // a latch write restarts the count at once, no stale long count
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q <= '0;
        end else if (load) begin
            cnt_q <= load_val; // see [R16]
        end else if (cnt_q <= W'(1)) begin
            cnt_q <= divisor; // see [R21]
        end else begin
            cnt_q <= cnt_q - W'(1); // see [R12]
        end
    end

    // divisor zero means not yet loaded: no enable at all
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            tick_q <= 1'b0;
        end else begin
            tick_q <= !load && (cnt_q == W'(1)); // see [R13]
        end
    end

    assign tick_16x = tick_q;

    // helper: cycles since last enable, and whether a reload intervened
    logic [W:0] since_q;
    logic       dirty_q;
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            since_q <= '0;
            dirty_q <= 1'b1;
        end else begin
            since_q <= tick_q ? (W+1)'(1) : (&since_q ? since_q : since_q + (W+1)'(1));
            dirty_q <= load ? 1'b1 : (tick_q ? 1'b0 : dirty_q);
        end
    end

    property p_tick_period;
        @(posedge mclk) disable iff (!rst_n)
        tick_q && !dirty_q |-> since_q == {1'b0, divisor};
    endproperty
    a_tick_period: assert property (p_tick_period) // see [R21]
        else $error("baud enable spacing differs from divisor");

    property p_reload;
        @(posedge mclk) disable iff (!rst_n)
        load |=> cnt_q == $past(load_val);
    endproperty
    a_reload: assert property (p_reload) // see [R16]
        else $error("divisor write did not reload the counter");

    property p_tick_single;
        @(posedge mclk) disable iff (!rst_n)
        tick_q && divisor > W'(1) && !load |=> !tick_q;
    endproperty
    a_tick_single: assert property (p_tick_single) // see [R13]
        else $error("baud enable longer than one cycle");

    c_tick: cover property (@(posedge mclk) disable iff (!rst_n)
        tick_q && !dirty_q);
endmodule : ums_baud_gen

/* verilog/ums_top.sv */
// modem line status register and baud generator behind AHB-Lite
// Contract
// [R1] reading status clears all four change flags
// [R2] bit 0 flags clear-to-send level change
// [R3] auto flow keeps CTS change flag clear
// [R4] bit 1 flags data-set-ready level change
// [R5] bit 2 sets on ring low-to-high only
// [R6] bit 3 flags carrier-detect level change
// [R7] set change flag with enable raises interrupt
// [R8] bit 4 inverted CTS, loop: RTS control
// [R9] bit 5 inverted DSR, loop: DTR control
// [R10] bit 6 inverted ring, loop: user output a
// [R11] bit 7 inverted carrier, loop: user output b
// [R12] divide reference clock by 1 to 65535
// [R13] generator output is sixteen times baud
// [R14] software divisor is clock over sixteen baud
// [R15] divisor held in two 8-bit latches
// [R16] latch write reloads the baud counter
// [R17] software loads both latches before use
// [R18] 1.8432 MHz with divisor 12 gives 9600
// [R19] access bit selects latches at shared offsets
// [R20] control bit 5 enables auto flow
// [R21] single-cycle enable per divisor count, reload
`timescale 1ns/1ps
module ums_top import ums_pkg::*; #(
    parameter int unsigned DW = DIV_W
) (
    input  wire logic        mclk,
    input  wire logic        rst_n,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic        cts_n,
    input  wire logic        dsr_n,
    input  wire logic        ri_n,
    input  wire logic        dcd_n,
    output logic             dtr_n,
    output logic             rts_n,
    output logic             user_output_a_n,
    output logic             user_output_b_n,
    output logic             modem_status_irq,
    output logic             baud_tick_16x
);
    generate
        if (DW != DIV_W) begin : g_bad_dw
            $error("ums_top: divisor must be 16 bits wide");
        end
    endgenerate

    // reset release through two flops
    logic rst_s1_q;
    logic rst_s2_q;
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rst_s1_q <= 1'b0;
            rst_s2_q <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1;
            rst_s2_q <= rst_s1_q;
        end
    end
    logic rst_sync_n;
    assign rst_sync_n = rst_s2_q;

    // modem pins pass two flops; only the second is read
    logic [3:0] pin_s1_q;
    logic [3:0] pin_s2_q;
    always_ff @(posedge mclk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            pin_s1_q <= 4'hF;
            pin_s2_q <= 4'hF;
        end else begin
            pin_s1_q <= {dcd_n, ri_n, dsr_n, cts_n};
            pin_s2_q <= pin_s1_q;
        end
    end

    // software-visible registers
    logic [7:0]        line_ctrl_q;
    logic [7:0]        int_en_q;
    logic [MCTL_W-1:0] modem_control_reg_q;
    logic [7:0]        div_lo_q;
    logic [7:0]        div_hi_q;
    logic [DW-1:0]     div_d;
    logic              div_load;

    // AHB-Lite address phase capture; zero wait states
    logic       acc;
    logic [5:0] acc_idx;
    logic       wr_pend_q;
    logic [5:0] wr_idx_q;
    assign acc     = hsel && htrans == HTRANS_NONSEQ && hready;
    assign acc_idx = haddr[ADDR_MSB:ADDR_LSB];

    always_ff @(posedge mclk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            wr_pend_q <= 1'b0;
            wr_idx_q  <= 6'h00;
        end else begin
            wr_pend_q <= acc && hwrite;
            wr_idx_q  <= acc_idx;
        end
    end

    logic divisor_latch_access;
    logic auto_flow_enable;
    logic loop_mode;
    assign divisor_latch_access = line_ctrl_q[LCTL_DIV_ACCESS];
    assign auto_flow_enable     = modem_control_reg_q[MCTL_AUTO_FLOW]; // see [R20]
    assign loop_mode            = modem_control_reg_q[MCTL_LOOP];

    logic wr_lo;
    logic wr_hi;
    logic wr_ier;
    assign wr_lo  = wr_pend_q && wr_idx_q == OFS_DIV_LO[ADDR_MSB:ADDR_LSB]
                    && divisor_latch_access;
    assign wr_hi  = wr_pend_q && wr_idx_q == OFS_DIV_HI_IER[ADDR_MSB:ADDR_LSB]
                    && divisor_latch_access;
    assign wr_ier = wr_pend_q && wr_idx_q == OFS_DIV_HI_IER[ADDR_MSB:ADDR_LSB]
                    && !divisor_latch_access;

    // divisor kept as two byte latches, each written alone
    always_ff @(posedge mclk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            div_lo_q <= DIV_RST[7:0];
            div_hi_q <= DIV_RST[15:8];
        end else begin
            if (wr_lo) begin
                div_lo_q <= hwdata[7:0]; // see [R15]
            end
            if (wr_hi) begin
                div_hi_q <= hwdata[7:0]; // see [R15]
            end
        end
    end

    // counter reload uses the value the latches are about to hold
    assign div_d    = {wr_hi ? hwdata[7:0] : div_hi_q, wr_lo ? hwdata[7:0] : div_lo_q};
    assign div_load = wr_lo || wr_hi; // see [R16]

    always_ff @(posedge mclk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            line_ctrl_q         <= REG_RST;
            int_en_q            <= REG_RST;
            modem_control_reg_q <= REG_RST[MCTL_W-1:0];
        end else begin
            if (wr_pend_q && wr_idx_q == OFS_LINE_CTRL[ADDR_MSB:ADDR_LSB]) begin
                line_ctrl_q <= hwdata[7:0];
            end
            if (wr_ier) begin
                int_en_q <= hwdata[7:0];
            end
            if (wr_pend_q && wr_idx_q == OFS_MODEM_CTRL[ADDR_MSB:ADDR_LSB]) begin
                modem_control_reg_q <= hwdata[MCTL_W-1:0];
            end
        end
    end

    // effective line levels: inverted pins, or control bits in loop test
    logic [3:0] lvl_now;
    logic [3:0] lvl_q;
    always_comb begin
        if (loop_mode) begin
            lvl_now[LN_CTS] = modem_control_reg_q[MCTL_RTS];    // see [R8]
            lvl_now[LN_DSR] = modem_control_reg_q[MCTL_DTR];    // see [R9]
            lvl_now[LN_RI]  = modem_control_reg_q[MCTL_USER_A]; // see [R10]
            lvl_now[LN_DCD] = modem_control_reg_q[MCTL_USER_B]; // see [R11]
        end else begin
            lvl_now = ~pin_s2_q; // see [R8] [R9] [R10] [R11]
        end
    end

    // levels start idle so reset itself is no change
    always_ff @(posedge mclk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            lvl_q <= 4'h0;
        end else begin
            lvl_q <= lvl_now;
        end
    end

    logic [3:0] chg_ev;
    assign chg_ev[LN_CTS] = (lvl_now[LN_CTS] != lvl_q[LN_CTS]) && !auto_flow_enable; // see [R3]
    assign chg_ev[LN_DSR] = lvl_now[LN_DSR] != lvl_q[LN_DSR]; // see [R4]
    // ring line rising = inverted level falling
    assign chg_ev[LN_RI]  = lvl_q[LN_RI] && !lvl_now[LN_RI]; // see [R5]
    assign chg_ev[LN_DCD] = lvl_now[LN_DCD] != lvl_q[LN_DCD]; // see [R6]

    logic rd_stat;
    assign rd_stat = acc && !hwrite && acc_idx == OFS_MODEM_STAT[ADDR_MSB:ADDR_LSB];

    // read clears the flags; an event on the same edge still sets
    logic [3:0] chg_q;
    always_ff @(posedge mclk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            chg_q <= 4'h0;
        end else begin
            chg_q <= chg_ev | (rd_stat ? 4'h0 : chg_q); // see [R1] [R2]
            if (auto_flow_enable) begin
                chg_q[MSTAT_CTS_CHG] <= 1'b0; // see [R3]
            end
        end
    end

    logic [7:0] modem_line_status;
    assign modem_line_status = {lvl_now, chg_q};

    // read data registered in the address phase, shown in the data phase
    logic [31:0] rdata_d;
    logic [31:0] hrdata_q;
    always_comb begin
        rdata_d = 32'h0000_0000;
        if (acc_idx == OFS_DIV_LO[ADDR_MSB:ADDR_LSB]) begin
            rdata_d[7:0] = divisor_latch_access ? div_lo_q : 8'h00;
        end else if (acc_idx == OFS_DIV_HI_IER[ADDR_MSB:ADDR_LSB]) begin
            rdata_d[7:0] = divisor_latch_access ? div_hi_q : int_en_q; // see [R19]
        end else if (acc_idx == OFS_LINE_CTRL[ADDR_MSB:ADDR_LSB]) begin
            rdata_d[7:0] = line_ctrl_q;
        end else if (acc_idx == OFS_MODEM_CTRL[ADDR_MSB:ADDR_LSB]) begin
            rdata_d[MCTL_W-1:0] = modem_control_reg_q;
        end else if (acc_idx == OFS_MODEM_STAT[ADDR_MSB:ADDR_LSB]) begin
            rdata_d[7:0] = modem_line_status;
        end
    end

    always_ff @(posedge mclk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            hrdata_q <= 32'h0000_0000;
        end else if (acc && !hwrite) begin
            hrdata_q <= rdata_d;
        end
    end

    assign hrdata    = hrdata_q;
    assign hreadyout = 1'b1;
    assign hresp     = HRESP_OKAY;

    // interrupt from any flag while enabled; CTS flag already gated
    logic irq_q;
    always_ff @(posedge mclk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= int_en_q[IER_MSI] && (|chg_q); // see [R7] [R3]
        end
    end
    assign modem_status_irq = irq_q;

    // outputs active low; loop test parks them inactive high
    logic [3:0] pins_out_q;
    always_ff @(posedge mclk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            pins_out_q <= 4'hF;
        end else if (loop_mode) begin
            pins_out_q <= 4'hF;
        end else begin
            pins_out_q <= ~{modem_control_reg_q[MCTL_USER_B], modem_control_reg_q[MCTL_USER_A],
                            modem_control_reg_q[MCTL_RTS], modem_control_reg_q[MCTL_DTR]};
        end
    end
    assign dtr_n           = pins_out_q[0];
    assign rts_n           = pins_out_q[1];
    assign user_output_a_n = pins_out_q[2];
    assign user_output_b_n = pins_out_q[3];

    // reference clock is mclk; above the rated maximum rate, a limitation
    ums_baud_gen #(
        .W (DW)
    ) u_baud (
        .mclk     (mclk),
        .rst_n    (rst_sync_n),
        .divisor  ({div_hi_q, div_lo_q}),
        .load     (div_load),
        .load_val (div_d),
        .tick_16x (baud_tick_16x)
    ); // see [R12] [R13]

    property p_read_clear;
        @(posedge mclk) disable iff (!rst_sync_n)
        rd_stat && chg_ev == 4'h0 |=> chg_q == 4'h0;
    endproperty
    a_read_clear: assert property (p_read_clear) // see [R1]
        else $error("status read did not clear change flags");

    property p_cts_chg;
        @(posedge mclk) disable iff (!rst_sync_n)
        lvl_now[LN_CTS] != lvl_q[LN_CTS] && !auto_flow_enable |=> chg_q[MSTAT_CTS_CHG];
    endproperty
    a_cts_chg: assert property (p_cts_chg) // see [R2]
        else $error("CTS change not flagged");

    property p_afe_clear;
        @(posedge mclk) disable iff (!rst_sync_n)
        auto_flow_enable |=> !chg_q[MSTAT_CTS_CHG];
    endproperty
    a_afe_clear: assert property (p_afe_clear) // see [R3]
        else $error("CTS flag set under auto flow");

    property p_dsr_chg;
        @(posedge mclk) disable iff (!rst_sync_n)
        $changed(lvl_now[LN_DSR]) ##0 lvl_now[LN_DSR] != lvl_q[LN_DSR] |=> chg_q[MSTAT_DSR_CHG];
    endproperty
    a_dsr_chg: assert property (p_dsr_chg) // see [R4]
        else $error("DSR change not flagged");

    property p_ring_edge_only_rise;
        @(posedge mclk) disable iff (!rst_sync_n)
        !chg_q[MSTAT_RING_EDGE] && !(lvl_q[LN_RI] && !lvl_now[LN_RI])
            |=> !chg_q[MSTAT_RING_EDGE];
    endproperty
    a_ring_edge_only_rise: assert property (p_ring_edge_only_rise) // see [R5]
        else $error("ring flag set without trailing edge");

    property p_dcd_chg;
        @(posedge mclk) disable iff (!rst_sync_n)
        lvl_now[LN_DCD] != lvl_q[LN_DCD] |=> chg_q[MSTAT_DCD_CHG];
    endproperty
    a_dcd_chg: assert property (p_dcd_chg) // see [R6]
        else $error("DCD change not flagged");

    property p_irq;
        @(posedge mclk) disable iff (!rst_sync_n)
        int_en_q[IER_MSI] && (|chg_q[MSTAT_DCD_CHG:MSTAT_DSR_CHG]) |=> modem_status_irq;
    endproperty
    a_irq: assert property (p_irq) // see [R7]
        else $error("modem status interrupt missing");

    property p_loop_lvl;
        @(posedge mclk) disable iff (!rst_sync_n)
        loop_mode |-> modem_line_status[7:MSTAT_LVL_LSB] ==
            {modem_control_reg_q[MCTL_USER_B], modem_control_reg_q[MCTL_USER_A],
             modem_control_reg_q[MCTL_DTR], modem_control_reg_q[MCTL_RTS]};
    endproperty
    a_loop_lvl: assert property (p_loop_lvl) // see [R8]
        else $error("loop levels do not follow control bits");

    property p_pin_lvl;
        @(posedge mclk) disable iff (!rst_sync_n)
        !loop_mode |-> modem_line_status[7:MSTAT_LVL_LSB] == ~pin_s2_q;
    endproperty
    a_pin_lvl: assert property (p_pin_lvl) // see [R9]
        else $error("levels are not the inverted pins");

    property p_div_latch;
        @(posedge mclk) disable iff (!rst_sync_n)
        wr_lo && !wr_hi |=> div_lo_q == $past(hwdata[7:0]) && $stable(div_hi_q);
    endproperty
    a_div_latch: assert property (p_div_latch) // see [R15]
        else $error("low divisor latch write misbehaved");

    c_stat_read: cover property (@(posedge mclk) disable iff (!rst_sync_n)
        rd_stat && chg_q != 4'h0);
    c_irq: cover property (@(posedge mclk) disable iff (!rst_sync_n)
        $rose(modem_status_irq));
    c_loop: cover property (@(posedge mclk) disable iff (!rst_sync_n)
        loop_mode && chg_q[MSTAT_RING_EDGE]);
endmodule : ums_top

/* test/ums_modem_model.sv */
// modem-side model driving the four handshake lines with a chosen lag
`timescale 1ns/1ps
module ums_modem_model (
    input  wire logic       mclk,
    input  wire logic       rst_n,
    input  wire logic [3:0] want,
    input  wire logic [3:0] lag,
    output logic            cts_n,
    output logic            dsr_n,
    output logic            ri_n,
    output logic            dcd_n
);
    logic [3:0] pin_q;
    logic [3:0] cnt_q;

    // want is active high {dcd,ri,dsr,cts}; pins idle high, change only after lag cycles
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            pin_q <= 4'hF;
            cnt_q <= 4'h0;
        end else if (pin_q == ~want) begin
            cnt_q <= 4'h0;
        end else if (cnt_q >= lag) begin
            pin_q <= ~want;
            cnt_q <= 4'h0;
        end else begin
            cnt_q <= cnt_q + 4'h1;
        end
    end

    assign cts_n = pin_q[0];
    assign dsr_n = pin_q[1];
    assign ri_n  = pin_q[2];
    assign dcd_n = pin_q[3];
endmodule : ums_modem_model

/* test/uart_modem_status_baud_gen_tb.sv */
// self-checking bench for the modem status register and baud generator
`timescale 1ns/1ps
module uart_modem_status_baud_gen_tb import ums_pkg::*;;
    logic        mclk = 1'b0;
    logic        rst_n = 1'b0;
    logic        hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0]  htrans = 2'h0;
    logic        hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic        hready;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
    logic        cts_n, dsr_n, ri_n, dcd_n;
    logic        dtr_n, rts_n, user_output_a_n, user_output_b_n;
    logic        modem_status_irq;
    logic        baud_tick_16x;
    logic [3:0]  want = 4'h0;
    logic [3:0]  lag = 4'h0;
    int          fails = 0;
    int          comparisons = 0;
    // reference model state: levels active high {dcd,ri,dsr,cts}
    logic [3:0]  lvl = 4'h0;
    logic [3:0]  flg = 4'h0;
    logic [3:0]  pin = 4'h0;
    logic [5:0]  modem_control_reg = 6'h0;
    logic        ier = 1'b0;

    assign hready = hreadyout;
    always #20 mclk = ~mclk;

    ums_top uut (.mclk(mclk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .cts_n(cts_n), .dsr_n(dsr_n), .ri_n(ri_n),
        .dcd_n(dcd_n), .dtr_n(dtr_n), .rts_n(rts_n), .user_output_a_n(user_output_a_n),
        .user_output_b_n(user_output_b_n), .modem_status_irq(modem_status_irq),
        .baud_tick_16x(baud_tick_16x));

    ums_modem_model modem (.mclk(mclk), .rst_n(rst_n), .want(want), .lag(lag),
        .cts_n(cts_n), .dsr_n(dsr_n), .ri_n(ri_n), .dcd_n(dcd_n));

    task automatic test_done;
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : test_done

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fails++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic bus(input logic [7:0] a, input logic wr, input logic [31:0] d,
                       output logic [31:0] q);
        int n;
        n = 0;
        @(posedge mclk);
        hsel   <= 1'b1;
        haddr  <= {24'h0, a};
        htrans <= HTRANS_NONSEQ;
        hwrite <= wr;
        do begin @(posedge mclk); n++; end while (hreadyout !== 1'b1 && n < 50);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do begin @(posedge mclk); n++; end while (hreadyout !== 1'b1 && n < 100);
        q = hrdata;
        if (n >= 100) fails++;
    endtask : bus

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(a, 1'b1, d, q);
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [31:0] q);
        bus(a, 1'b0, 32'h0, q);
    endtask : rd

    // bounded wait for the next tick, n = cycles waited
    task automatic gap(output int n);
        n = 0;
        do begin @(posedge mclk); #1; n++; end while (baud_tick_16x !== 1'b1 && n < 3000);
    endtask : gap

    // loop mode feeds {user_b,user_a,dtr,rts} in place of the pins
    task automatic model_upd;
        logic [3:0] nl;
        logic [3:0] ch;
        nl = modem_control_reg[MCTL_LOOP] ? {modem_control_reg[3], modem_control_reg[2], modem_control_reg[0], modem_control_reg[1]} : pin;
        ch = nl ^ lvl;
        if (ch[0]) flg[0] = 1'b1;
        if (ch[1]) flg[1] = 1'b1;
        if (lvl[2] && !nl[2]) flg[2] = 1'b1;
        if (ch[3]) flg[3] = 1'b1;
        if (modem_control_reg[MCTL_AUTO_FLOW]) flg[0] = 1'b0;
        lvl = nl;
    endtask : model_upd

    initial begin : watchdog
        // about 10k cycles, several times the expected run length
        #400_000;
        fails++;
        test_done();
    end

    initial begin : main
        logic [31:0] q;
        int          n;
        int          divs[5];
        void'($urandom(32'hF42F0155));
        repeat (20) @(posedge mclk);
        rst_n <= 1'b1;
        repeat (3) @(posedge mclk);
        rd(OFS_MODEM_STAT, q);
        check(q, 32'h0);
        check({hresp, hreadyout}, 32'h1);
        wr(8'h08, 32'h5A);
        rd(8'h08, q);
        check(q, 32'h0);
        rd(OFS_DIV_LO, q);
        check(q, 32'h0);
        for (int i = 0; i < 24; i++) begin
            if (i == 0) begin wr(OFS_DIV_HI_IER, 32'h08); ier = 1'b1; end
            if (i == 12) begin wr(OFS_DIV_HI_IER, 32'h00); ier = 1'b0; end
            modem_control_reg = 6'($urandom);
            wr(OFS_MODEM_CTRL, {26'h0, modem_control_reg});
            model_upd();
            pin = 4'($urandom);
            want <= pin;
            lag <= 4'($urandom_range(3));
            model_upd();
            repeat (9) @(posedge mclk);
            #1;
            check(modem_status_irq, {31'h0, ier && (flg != 4'h0)});
            check({user_output_b_n, user_output_a_n, rts_n, dtr_n},
                  modem_control_reg[MCTL_LOOP] ? 4'hF : {28'h0, ~modem_control_reg[3:0]});
            rd(OFS_MODEM_CTRL, q);
            check(q, {26'h0, modem_control_reg});
            rd(OFS_MODEM_STAT, q);
            check(q, {24'h0, lvl, flg});
            flg = 4'h0;
            repeat (3) @(posedge mclk);
            #1;
            check(modem_status_irq, 32'h0);
            rd(OFS_MODEM_STAT, q);
            check(q, {24'h0, lvl, 4'h0});
        end
        wr(OFS_MODEM_CTRL, 32'h0);
        // 1, 3, 12 and 96 are the divisors that software derives from ref / (16 * baud)
        divs = '{1, 3, 12, 96, int'($urandom_range(40, 2))};
        foreach (divs[k]) begin
            wr(OFS_LINE_CTRL, 32'h80);
            wr(OFS_DIV_HI_IER, divs[k] >> 8);
            wr(OFS_DIV_LO, divs[k] & 8'hFF);
            rd(OFS_DIV_LO, q);
            check(q, divs[k] & 8'hFF);
            rd(OFS_DIV_HI_IER, q);
            check(q, divs[k] >> 8);
            wr(OFS_LINE_CTRL, 32'h00);
            gap(n);
            gap(n);
            check(n, divs[k]);
        end
        // stale long count must be dropped when the high latch is rewritten
        wr(OFS_LINE_CTRL, 32'h80);
        wr(OFS_DIV_HI_IER, 32'h03);
        wr(OFS_DIV_LO, 32'h05);
        wr(OFS_DIV_HI_IER, 32'h00);
        gap(n);
        check(n <= 7, 32'h1);
        gap(n);
        check(n, 32'd5);
        test_done();
    end
endmodule : uart_modem_status_baud_gen_tb
